// *** src/uhx_host_xfer.v ***
// ultra dma burst engine of the host port with its firmware registers
//
// How it works
// - a burst runs from dma_ack_n falling until it rises again.
// - mode 9h or Bh renames ready, read and write pins during bursts.
// - data-in strobe period is two plus timing_factor burst clocks.
// - burst_clock_select picks system clock or alternate burst clock.
// - modes 0 to 2 are reachable through timing_factor 2, 1, 0.
// - data-out accepts one word more than word_count.
// - data-out words land in a 12-byte packet fifo; count five fills.
// - firmware drains the fifo port until fifo_not_empty_n reads one.
// - burst_crc_ok_n at status bit 3 flags a crc error last burst.
// - crc gate with auto status blocks completion after a crc error.
// - status completion raises host_interrupt if selected and enabled.
`timescale 1ns/1ps
`default_nettype none
`include "uhx_regs.vh"
module uhx_host_xfer (
  input wire clk_in,
  input wire reset_n_in,
  input wire [7:0] mcu_addr_in,
  input wire [7:0] mcu_wdata_in,
  input wire mcu_wr_in,
  input wire mcu_rd_in,
  output reg [7:0] mcu_rdata_out,
  input wire dma_ack_n_in,
  input wire pin50_in,
  input wire pin52_in,
  input wire burst_alt_clk_in,
  input wire [15:0] dd_in,
  output reg [15:0] dd_out,
  output reg dd_oe_n_out,
  output reg pin49_out,
  output reg dmarq_out,
  input wire drive_selected_in,
  input wire host_irq_enable_in,
  input wire host_irq_clear_in,
  output reg host_interrupt_out,
  output reg status_complete_out,
  input wire din_valid_in,
  input wire [15:0] din_data_in,
  output reg din_ready_out
);
  // ----------------------------------------------------------------
  // crc step, one word msb first
  // ----------------------------------------------------------------
  function [15:0] uhx_crc;
    input [15:0] crc;
    input [15:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 15; i >= 0; i = i - 1) begin
        if (c[15] ^ data[i]) begin
          c = {c[14:0], 1'b0} ^ `UHX_CRC_POLY;
        end else begin
          c = {c[14:0], 1'b0};
        end
      end
      uhx_crc = c;
    end
  endfunction
  // ----------------------------------------------------------------
  // synchronisers for pins and the alternate burst clock
  // ----------------------------------------------------------------
  reg [19:0] sync1_reg;
  reg [19:0] sync2_reg;
  reg [3:0] last_reg;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_reg <= 20'hFFFFF;
      sync2_reg <= 20'hFFFFF;
      last_reg <= 4'hF;
    end else begin
      sync1_reg <= {burst_alt_clk_in, pin52_in, pin50_in, dma_ack_n_in,
                    dd_in};
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg[19:16];
    end
  end
  wire [15:0] dd_s = sync2_reg[15:0];
  wire ack_n_s = sync2_reg[16];
  wire pin50_s = sync2_reg[17];
  wire stop_s = sync2_reg[18];
  wire burst = !ack_n_s;
  wire burst_start = last_reg[0] && !ack_n_s;
  wire burst_end = !last_reg[0] && ack_n_s;
  wire strobe_edge = pin50_s ^ last_reg[1];
  wire alt_rise = sync2_reg[19] && !last_reg[3];
  // ----------------------------------------------------------------
  // firmware registers
  // ----------------------------------------------------------------
  reg [15:0] word_count_reg;
  reg [7:0] mode_reg;
  reg [7:0] auto_ctrl_reg;
  reg [7:0] error_reg;
  reg [7:0] timing_reg;
  reg xfer_end_irq_enable_reg;
  reg xfer_end_n_reg;
  reg packet_phase_reg;
  reg crc_ok_n_reg;
  reg active_reg;
  reg [15:0] crc_reg;
  reg [16:0] words_reg;
  reg ack_seen_reg;
  wire wr = mcu_wr_in;
  wire trig_wr = wr && mcu_addr_in == `UHX_XFER_TRIGGER;
  wire start_xfer = trig_wr && mcu_wdata_in[`UHX_AUTO_XFER_TRIG_BIT];
  wire status_complete_trigger = trig_wr && mcu_wdata_in[`UHX_STATUS_COMPLETE_TRIG_BIT];
  wire mode_in = mode_reg[3:0] == `UHX_MODE_DATA_IN;
  wire mode_out = mode_reg[3:0] == `UHX_MODE_DATA_OUT;
  wire [16:0] target = {1'b0, word_count_reg} + 17'h00001;
  wire done = words_reg == target;
  wire [1:0] tfactor =
    timing_reg[`UHX_TIMING_FACTOR_HI:`UHX_TIMING_FACTOR_LO];
  wire clk_sel = timing_reg[`UHX_CLOCK_SELECT_BIT];
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      word_count_reg <= `UHX_RESET_WORD;
      mode_reg <= `UHX_RESET_BYTE;
      auto_ctrl_reg <= `UHX_RESET_BYTE;
      error_reg <= `UHX_RESET_BYTE;
      timing_reg <= `UHX_RESET_BYTE;
      xfer_end_irq_enable_reg <= 1'b0;
    end else if (wr) begin
      case (mcu_addr_in)
        `UHX_WORD_COUNT_LO: word_count_reg[7:0] <= mcu_wdata_in;
        `UHX_WORD_COUNT_HI: word_count_reg[15:8] <= mcu_wdata_in;
        `UHX_HOST_IF_MODE: mode_reg <= mcu_wdata_in;
        `UHX_AUTOMATION_CTRL: auto_ctrl_reg <= mcu_wdata_in;
        `UHX_ERROR_REPORT: error_reg <= mcu_wdata_in;
        `UHX_BURST_TIMING: timing_reg <= mcu_wdata_in;
        `UHX_INTR_STATUS_CTRL: begin
          xfer_end_irq_enable_reg <= mcu_wdata_in[`UHX_XFER_END_IRQ_EN_BIT];
        end
        default: begin
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // data-out path: strobe capture, buffer, packet fifo
  // ----------------------------------------------------------------
  wire cap = burst && mode_out && active_reg && strobe_edge && !done;
  wire buf_ready;
  wire buf_valid;
  wire [15:0] buf_data;
  reg [15:0] pf_mem [0:5];
  reg [2:0] pf_wr_reg;
  reg [3:0] pf_rd_reg;
  reg [3:0] pf_bytes_reg;
  wire pf_take = buf_valid && pf_bytes_reg <= 4'hA;
  wire pf_pop = mcu_rd_in && mcu_addr_in == `UHX_PACKET_FIFO_PORT &&
                pf_bytes_reg != 4'h0;
  wire [15:0] pf_word = pf_mem[pf_rd_reg[3:1]];
  wire [7:0] pf_byte = pf_rd_reg[0] ? pf_word[15:8] : pf_word[7:0];
  uhx_buf2 #(
    .WIDTH(16)
  ) i_uhx_buf2 (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(cap),
    .in_data_in(dd_s),
    .in_ready_out(buf_ready),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(pf_take)
  );
  integer k;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (k = 0; k < 6; k = k + 1) begin
        pf_mem[k] <= `UHX_RESET_WORD;
      end
      pf_wr_reg <= 3'h0;
      pf_rd_reg <= 4'h0;
      pf_bytes_reg <= 4'h0;
    end else begin
      if (pf_take) begin
        pf_mem[pf_wr_reg] <= buf_data;
        pf_wr_reg <= (pf_wr_reg == 3'h5) ? 3'h0 : pf_wr_reg + 3'h1;
      end
      if (pf_pop) begin
        pf_rd_reg <= (pf_rd_reg == `UHX_PACKET_BYTES - 4'h1) ? 4'h0 :
                     pf_rd_reg + 4'h1;
      end
      pf_bytes_reg <= pf_bytes_reg + (pf_take ? 4'h2 : 4'h0) -
                      {3'h0, pf_pop};
    end
  end
  // ----------------------------------------------------------------
  // data-in strobe timing
  // ----------------------------------------------------------------
  // alternate clock is oversampled, so it must stay well below clk_in/2
  wire tick = clk_sel ? alt_rise : 1'b1;
  reg [2:0] cyc_reg;
  reg [15:0] hold_reg;
  reg hold_valid_reg;
  wire din_go = burst && mode_in && active_reg && !pin50_s && !stop_s &&
                !done && hold_valid_reg;
  wire cyc_last = cyc_reg >= `UHX_CYCLE_BASE - 3'h1 + {1'b0, tfactor};
  wire send = din_go && tick && cyc_last;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cyc_reg <= 3'h0;
      hold_reg <= `UHX_RESET_WORD;
      hold_valid_reg <= 1'b0;
      din_ready_out <= 1'b0;
    end else begin
      if (!din_go) begin
        cyc_reg <= 3'h0;
      end else if (tick) begin
        cyc_reg <= cyc_last ? 3'h0 : cyc_reg + 3'h1;
      end
      din_ready_out <= 1'b0;
      if (din_valid_in && !din_ready_out && (!hold_valid_reg || send)) begin
        hold_reg <= din_data_in;
        hold_valid_reg <= 1'b1;
        din_ready_out <= 1'b1;
      end else if (send) begin
        hold_valid_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // transfer control, crc and pins
  // ----------------------------------------------------------------
  wire end_now = active_reg && done && ack_seen_reg && ack_n_s &&
                 last_reg[0];
  wire gate = auto_ctrl_reg[`UHX_CRC_GATE_EN_BIT] && crc_ok_n_reg;
  wire auto_sc = end_now && auto_ctrl_reg[`UHX_AUTO_STATUS_EN_BIT] &&
                 !gate;
  wire run_sc = auto_sc || status_complete_trigger;
  wire ack_wr = wr && mcu_addr_in == `UHX_XFER_ACK &&
                mcu_wdata_in == `UHX_ACK_ALL;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      active_reg <= 1'b0;
      words_reg <= 17'h00000;
      ack_seen_reg <= 1'b0;
      crc_reg <= `UHX_CRC_INIT;
      crc_ok_n_reg <= 1'b0;
      xfer_end_n_reg <= 1'b1;
      packet_phase_reg <= 1'b0;
      dmarq_out <= 1'b0;
      pin49_out <= 1'b1;
      dd_out <= `UHX_RESET_WORD;
      dd_oe_n_out <= 1'b1;
      host_interrupt_out <= 1'b0;
      status_complete_out <= 1'b0;
    end else begin
      if (start_xfer) begin
        active_reg <= 1'b1;
        words_reg <= 17'h00000;
        ack_seen_reg <= 1'b0;
        packet_phase_reg <= 1'b0;
      end else if (end_now) begin
        active_reg <= 1'b0;
      end else if (cap || send) begin
        words_reg <= words_reg + 17'h00001;
      end
      if (burst && active_reg) begin
        ack_seen_reg <= 1'b1;
      end
      if (burst_start) begin
        crc_reg <= `UHX_CRC_INIT;
      end else if (cap) begin
        crc_reg <= uhx_crc(crc_reg, dd_s);
      end else if (send) begin
        crc_reg <= uhx_crc(crc_reg, hold_reg);
      end
      if (burst_end) begin
        // host places its crc on the bus before releasing the ack
        crc_ok_n_reg <= mode_out && (dd_s != crc_reg);
      end
      // end event wins over a simultaneous acknowledge
      if (end_now) begin
        xfer_end_n_reg <= 1'b0;
        packet_phase_reg <= mode_out;
      end else if (ack_wr) begin
        xfer_end_n_reg <= 1'b1;
      end
      dmarq_out <= active_reg && !done && !start_xfer && !end_now;
      if (burst && mode_in) begin
        if (send) begin
          pin49_out <= !pin49_out;
          dd_out <= hold_reg;
        end else if (stop_s) begin
          dd_out <= crc_reg;
        end
        dd_oe_n_out <= 1'b0;
      end else if (burst && mode_out) begin
        pin49_out <= !(buf_ready && active_reg && !done);
        dd_oe_n_out <= 1'b1;
      end else begin
        pin49_out <= 1'b1;
        dd_oe_n_out <= 1'b1;
      end
      status_complete_out <= run_sc;
      if (run_sc && drive_selected_in && host_irq_enable_in) begin
        host_interrupt_out <= 1'b1;
      end else if (host_irq_clear_in) begin
        host_interrupt_out <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  reg [7:0] rd_next;
  always @* begin
    rd_next = `UHX_RESET_BYTE;
    case (mcu_addr_in)
      `UHX_PACKET_FIFO_PORT: rd_next = pf_byte;
      `UHX_INTR_STATUS_CTRL: begin
        rd_next[`UHX_FIFO_NOT_EMPTY_N_BIT] = pf_bytes_reg == 4'h0;
        rd_next[`UHX_XFER_END_N_BIT] = xfer_end_n_reg;
      end
      `UHX_XFER_STATUS: begin
        rd_next[`UHX_XFER_DIR_BIT] = mode_out;
        rd_next[`UHX_CRC_OK_N_BIT] = crc_ok_n_reg;
        rd_next[`UHX_PACKET_PHASE_BIT] = packet_phase_reg;
      end
      `UHX_ERROR_REPORT: rd_next = error_reg;
      `UHX_BURST_TIMING: rd_next = timing_reg;
      default: rd_next = `UHX_RESET_BYTE;
    endcase
  end
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mcu_rdata_out <= `UHX_RESET_BYTE;
    end else if (mcu_rd_in) begin
      mcu_rdata_out <= rd_next;
    end
  end
endmodule
`default_nettype wire

// *** src/uhx_regs.vh ***
// register map, field positions and reset values of the ultra dma host port
`ifndef UHX_REGS_VH
`define UHX_REGS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UHX_PACKET_FIFO_PORT 8'h00
`define UHX_INTR_STATUS_CTRL 8'h01
`define UHX_WORD_COUNT_LO 8'h02
`define UHX_WORD_COUNT_HI 8'h03
`define UHX_XFER_ACK 8'h07
`define UHX_XFER_TRIGGER 8'h17
`define UHX_AUTOMATION_CTRL 8'h18
`define UHX_HOST_IF_MODE 8'h1F
`define UHX_XFER_STATUS 8'h30
`define UHX_ERROR_REPORT 8'h37
`define UHX_BURST_TIMING 8'h8A
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UHX_FIFO_NOT_EMPTY_N_BIT 7
`define UHX_XFER_END_N_BIT 6
`define UHX_XFER_END_IRQ_EN_BIT 6
`define UHX_STATUS_COMPLETE_TRIG_BIT 0
`define UHX_AUTO_XFER_TRIG_BIT 2
`define UHX_AUTO_STATUS_EN_BIT 5
`define UHX_CRC_GATE_EN_BIT 2
`define UHX_XFER_DIR_BIT 5
`define UHX_CRC_OK_N_BIT 3
`define UHX_PACKET_PHASE_BIT 1
`define UHX_CHECK_ERROR_BIT 0
`define UHX_TIMING_FACTOR_HI 5
`define UHX_TIMING_FACTOR_LO 4
`define UHX_CLOCK_SELECT_BIT 3
// ----------------------------------------------------------------
// mode codes, constants and reset values
// ----------------------------------------------------------------
`define UHX_MODE_DATA_IN 4'h9
`define UHX_MODE_DATA_OUT 4'hB
`define UHX_CYCLE_BASE 3'h2
`define UHX_PACKET_BYTES 4'hC
`define UHX_CRC_INIT 16'h4ABA
`define UHX_CRC_POLY 16'h1021
`define UHX_ACK_ALL 8'hFF
`define UHX_RESET_BYTE 8'h00
`define UHX_RESET_WORD 16'h0000
`endif

// *** src/uhx_buf2.v ***
// two-entry valid/ready buffer in the data-out word path
`timescale 1ns/1ps
`default_nettype none
module uhx_buf2 #(
  parameter WIDTH = 16
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);
  reg [WIDTH-1:0] slot0_reg;
  reg [WIDTH-1:0] slot1_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;
  assign in_ready_out = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = slot0_reg;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slot0_reg <= {WIDTH{1'b0}};
      slot1_reg <= {WIDTH{1'b0}};
      count_reg <= 2'h0;
    end else begin
      // oldest word always sits in slot0
      if (pop) begin
        slot0_reg <= (push && count_reg == 2'h1) ? in_data_in : slot1_reg;
      end else if (push && count_reg == 2'h0) begin
        slot0_reg <= in_data_in;
      end
      if (push && ((count_reg == 2'h1 && !pop) || count_reg == 2'h2)) begin
        slot1_reg <= in_data_in;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// *** testbench/uhx_monitor.sv ***
// assertion checker for the ultra dma host port
`timescale 1ns/1ps
`default_nettype none
module uhx_monitor (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] mcu_addr_in,
  input wire logic [7:0] mcu_wdata_in,
  input wire logic mcu_wr_in,
  input wire logic mcu_rd_in,
  input wire logic [7:0] mcu_rdata_out,
  input wire logic dma_ack_n_in,
  input wire logic dd_oe_n_out,
  input wire logic pin49_out,
  input wire logic dmarq_out,
  input wire logic host_irq_clear_in,
  input wire logic host_interrupt_out,
  input wire logic status_complete_out
);
  logic [2:0] idle_cnt;
  logic [2:0] trig_age;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ---------------------------------------------
  // helper counters
  // ---------------------------------------------
  // idle_cnt saturates so pin checks wait out the ack synchroniser
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idle_cnt <= 3'h0;
      trig_age <= 3'h7;
    end else begin
      idle_cnt <= !dma_ack_n_in ? 3'h0 : idle_cnt + {2'h0, idle_cnt != 3'h7};
      if (mcu_wr_in && mcu_addr_in == 8'h17 && mcu_wdata_in[2])
        trig_age <= 3'h0;
      else
        trig_age <= trig_age + {2'h0, trig_age != 3'h7};
    end
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  a_idle_pins: assert property (
    idle_cnt == 3'h7 |-> pin49_out && dd_oe_n_out)
    else $error("pins not idle outside burst");
  a_dmarq_cause: assert property ($rose(dmarq_out) |-> trig_age <= 3'h4)
    else $error("dma request without trigger");
  a_sc_pulse: assert property (
    status_complete_out |=> !status_complete_out)
    else $error("completion pulse too long");
  a_sct_answer: assert property (
    mcu_wr_in && mcu_addr_in == 8'h17 && mcu_wdata_in[0]
    |-> ##[1:3] status_complete_out)
    else $error("status trigger ignored");
  a_irq_cause: assert property (
    $rose(host_interrupt_out) |-> status_complete_out)
    else $error("host interrupt without completion");
  a_irq_clear: assert property (
    host_irq_clear_in |=> status_complete_out || !host_interrupt_out)
    else $error("host interrupt not cleared");
  a_rdata_hold: assert property (!mcu_rd_in |=> $stable(mcu_rdata_out))
    else $error("read data changed without read");
  a_rd_unmapped: assert property (mcu_rd_in && mcu_addr_in == 8'h40
    |=> mcu_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind uhx_host_xfer uhx_monitor i_uhx_monitor (.clk_in, .reset_n_in,
  .mcu_addr_in, .mcu_wdata_in, .mcu_wr_in, .mcu_rd_in, .mcu_rdata_out,
  .dma_ack_n_in, .dd_oe_n_out, .pin49_out, .dmarq_out, .host_irq_clear_in,
  .host_interrupt_out, .status_complete_out);
`default_nettype wire

// *** testbench/uhx_host_model.sv ***
// host controller model driving ultra dma bursts
`timescale 1ns/1ps
`default_nettype none
module uhx_host_model (
  input wire logic clk_in,
  input wire logic pin49_in,
  output logic dma_ack_n_out,
  output logic pin50_out,
  output logic pin52_out,
  output logic [15:0] dd_out
);
  logic [15:0] crc;
  int k;
  // pulled-up pins idle high; a released bus floats up too
  initial begin
    dma_ack_n_out = 1'b1;
    pin50_out = 1'b1;
    pin52_out = 1'b1;
    dd_out = 16'hFFFF;
  end
  function automatic logic [15:0] step(input logic [15:0] c,
                                       input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task out_burst(input int n, input logic bad);
    crc = 16'h4ABA;
    @(negedge clk_in);
    dma_ack_n_out = 1'b0;
    pin52_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      k = 0;
      // wait up to 60 cycles for the device to be ready before strobing
      while (pin49_in !== 1'b0 && k < 60) begin
        @(negedge clk_in);
        k++;
      end
      // data settles a cycle ahead of the strobe so the synced word is whole
      dd_out = {8'hC3, 8'(i)};
      crc = step(crc, dd_out);
      @(negedge clk_in);
      pin50_out = ~pin50_out;
      repeat (3) @(negedge clk_in);
    end
    pin52_out = 1'b1;
    dd_out = bad ? ~crc : crc;
    repeat (4) @(negedge clk_in);
    dma_ack_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
    dd_out = 16'hFFFF;
    pin50_out = 1'b1;
  endtask
  task in_start();
    @(negedge clk_in);
    dma_ack_n_out = 1'b0;
    pin52_out = 1'b0;
    pin50_out = 1'b0;
  endtask
  task in_stop();
    pin52_out = 1'b1;
    repeat (4) @(negedge clk_in);
    dma_ack_n_out = 1'b1;
    pin50_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_uhx_host_xfer.sv ***
// self-checking bench of the ultra dma host port
`timescale 1ns/1ps
`default_nettype none
module test_uhx_host_xfer;
  logic clk = 1'b0;
  logic alt = 1'b0;
  logic rst_n, wr, rd, ack_n, p50, p52, oe_n, p49, dmarq;
  logic sel, ien, iclr, irq, sc, dv, dr;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] hdd, ddev, ddat;
  wire [15:0] dd = oe_n ? hdd : ddev;
  int errors, n_compared, cyc, n_sc, n_dr;
  uhx_host_xfer i_uhx_host_xfer (.clk_in(clk), .reset_n_in(rst_n),
    .mcu_addr_in(addr), .mcu_wdata_in(wdata), .mcu_wr_in(wr), .mcu_rd_in(rd),
    .mcu_rdata_out(rdata), .dma_ack_n_in(ack_n), .pin50_in(p50),
    .pin52_in(p52), .burst_alt_clk_in(alt), .dd_in(dd), .dd_out(ddev),
    .dd_oe_n_out(oe_n), .pin49_out(p49), .dmarq_out(dmarq),
    .drive_selected_in(sel), .host_irq_enable_in(ien),
    .host_irq_clear_in(iclr), .host_interrupt_out(irq),
    .status_complete_out(sc), .din_valid_in(dv), .din_data_in(ddat),
    .din_ready_out(dr));
  uhx_host_model i_uhx_host_model (.clk_in(clk), .pin49_in(p49),
    .dma_ack_n_out(ack_n), .pin50_out(p50), .pin52_out(p52), .dd_out(hdd));
  initial forever #5 clk = ~clk;
  initial begin
    #3;
    forever #62.5 alt = ~alt;
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (sc === 1'b1) n_sc++;
    if (dr === 1'b1) n_dr++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  task conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_t(input time got, input int exp, input int tol);
    n_compared++;
    if (got + tol < exp || got > exp + tol) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask
  task start(input logic [7:0] mode, input logic [7:0] cnt);
    wr_reg(8'h1F, mode);
    wr_reg(8'h02, cnt);
    wr_reg(8'h03, 8'h00);
    wr_reg(8'h17, 8'h04);
  endtask
  task end_ack();
    logic [7:0] v;
    int k;
    k = 0;
    v = 8'h40;
    while (v[6] !== 1'b0 && k < 60) begin
      rd_reg(8'h01, v);
      k++;
    end
    chk(v & 8'h40, 8'h00);
    wr_reg(8'h07, 8'hFF);
  endtask
  task tog();
    logic l;
    int k;
    l = p49;
    k = 0;
    while (p49 === l && k < 100) begin
      @(negedge clk);
      k++;
    end
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_regs();
    logic [7:0] v;
    rd_reg(8'h01, v);
    chk(v & 8'hC0, 8'hC0);
    wr_reg(8'h8A, 8'h38);
    rd_reg(8'h8A, v);
    chk(v & 8'h38, 8'h38);
    rd_reg(8'h40, v);
    chk(v, 8'h00);
    $display("test registers done");
  endtask
  task t_out(input logic bad, input logic [7:0] actl, input int exp_sc);
    logic [7:0] v;
    int s;
    s = n_sc;
    wr_reg(8'h01, 8'h40);
    wr_reg(8'h18, actl);
    start(8'h0B, 8'h04);
    chk({7'h00, dmarq}, 8'h01);
    i_uhx_host_model.out_burst(5, bad);
    end_ack();
    chk({7'h00, dmarq}, 8'h00);
    rd_reg(8'h30, v);
    chk(v & 8'h2A, bad ? 8'h2A : 8'h22);
    chk(8'(n_sc - s), 8'(exp_sc));
    chk({7'h00, irq}, 8'(exp_sc));
    for (int k = 0; k < 10; k++) begin
      rd_reg(8'h00, v);
      chk(v, k[0] ? 8'hC3 : 8'(k / 2));
    end
    rd_reg(8'h01, v);
    chk(v & 8'hC0, 8'hC0);
    iclr = 1'b1;
    @(negedge clk);
    iclr = 1'b0;
    chk({7'h00, irq}, 8'h00);
    $display("test data-out done");
  endtask
  task t_sct();
    logic [7:0] v;
    int s;
    s = n_sc;
    wr_reg(8'h37, 8'h01);
    rd_reg(8'h37, v);
    chk(v & 8'h01, 8'h01);
    wr_reg(8'h17, 8'h01);
    chk(8'(n_sc - s), 8'h01);
    chk({7'h00, irq}, 8'h01);
    $display("test manual completion done");
  endtask
  task t_in(input logic [1:0] f, input logic s, input int exp, input int tol);
    time t0;
    int d;
    d = n_dr;
    wr_reg(8'h8A, {2'b00, f, s, 3'b000});
    start(8'h09, 8'h01);
    i_uhx_host_model.in_start();
    tog();
    t0 = $time;
    chk({7'h00, oe_n}, 8'h00);
    tog();
    chk_t($time - t0, exp, tol);
    chk(ddev[15:8], 8'hA5);
    i_uhx_host_model.in_stop();
    end_ack();
    chk(8'(n_dr - d), 8'h02);
    $display("test data-in done");
  endtask
  initial begin
    rst_n = 1'b0;
    {wr, rd, iclr} = 3'b000;
    {addr, wdata} = 16'h0000;
    {sel, ien, dv} = 3'b111;
    ddat = 16'hA55A;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_out(1'b0, 8'h58, 0);
    t_out(1'b1, 8'h24, 0);
    t_out(1'b0, 8'h24, 1);
    t_sct();
    // factor rises step by step, as firmware would back off after crc errors
    for (int f = 0; f < 3; f++) begin
      t_in(f[1:0], 1'b0, (2 + f) * 10, 0);
    end
    t_in(2'h0, 1'b1, 250, 20);
    conclude();
  end
endmodule
`default_nettype wire
